// ==== wakeup_unit_regs.svh ====
// Register offsets, field positions and reset values of the wakeup unit
`ifndef WAKEUP_UNIT_REGS_SVH
`define WAKEUP_UNIT_REGS_SVH

`define OFF_REGSC       12'h000
`define OFF_PIN_EDGE_LO 12'h004
`define OFF_PIN_EDGE_HI 12'h008
`define OFF_MOD_ENABLE  12'h00C
`define OFF_PIN_FLAG    12'h010
`define OFF_MOD_FLAG    12'h014
`define OFF_FILT_CFG    12'h018
`define OFF_MODE_CTRL   12'h01C

`define BIT_BUF_EN      0
`define BIT_RSVD1       1
`define BIT_REG_RUN     2
`define BIT_ISO_ACK     3
`define BIT_BG_KEEP     4
`define BIT_RSVD5       5

`define FILT_EN_BIT     7
`define FILT_PIN_LSB    0
`define FILT_PIN_MSB    3
`define FILT_EDGE_LSB   4
`define FILT_EDGE_MSB   5

`define EDGE_OFF        2'h0
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`define EDGE_ANY        2'h3

`define FILT_LEN        3'h5
`define RST_WORD        32'h0000_0000
`define ERR_DATA        32'hDEAD_0000

`endif

// ==== wakeup_unit_pkg.sv ====
// Types shared by the wakeup unit files
package wakeup_unit_pkg;
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_LLS  = 4'h2,
    ST_VLLS = 4'h4,
    ST_HOLD = 4'h8
  } wake_state_t;
  typedef enum logic [2:0] {
    MODE_RUN  = 3'h0,
    MODE_LLS  = 3'h1,
    MODE_VLLS = 3'h2,
    MODE_VLL0 = 3'h3
  } power_mode_t;
endpackage

// ==== wake_pin_filter.sv ====
// Digital filter that needs a stable pin level for a number of samples
`timescale 1ns/1ps
`include "wakeup_unit_regs.svh"
module wake_pin_filter #(
  parameter int CNT_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             tick_i,
  input  wire logic             pin_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  level_o
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end else if (pin_i == level_o) begin
      cnt_reg <= '0;
    end else if (tick_i) begin
      if (cnt_reg + CNT_W'(1) >= len_i) begin
        level_o <= pin_i;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end
endmodule // wake_pin_filter

// ==== wakeup_unit.sv ====
// Low-leakage wakeup unit with regulator status and control over APB
// How it works
// - Bandgap keep-on holds reference in low modes
// - Isolation bit latched; write one releases pads
// - Regulator run status is read-only
// - Buffer enable bit drives reference buffer
// - Bit 1 and all bits above bit 4 read zero
// - Sixteen pins, eight modules, each enabled
// - Pins detect rising, falling or any edge
// - Two filters qualify selected wakeup pins
// - Deepest mode bypasses both filters
// - Detection only in low modes and deep recovery hold, enabled sources
// - Leak stop recovery disables unit at once
// - Deep recovery detects until isolation acknowledged
// - Leak stop wakeup exits by interrupt flow
// - Deep mode wakeup exits by reset flow
// - Outside low modes and deep recovery hold detection static, registers live
// - Filters run at once; early pin edges caught, early filter edges not
// - Entry from debug leaves unit inactive after
// - Edge code 00 off,01 rise,10 fall,11 any
// - Flags record which source caused wakeup
`timescale 1ns/1ps
`include "wakeup_unit_regs.svh"
module wakeup_unit
  import wakeup_unit_pkg::*;
#(
  parameter int NPIN  = 16,
  parameter int NMOD  = 8,
  parameter int NFILT = 2
) (
  input  wire logic            SYS_CLK_I,
  input  wire logic            NRST_I,
  input  wire logic            PSEL_I,
  input  wire logic            PENABLE_I,
  input  wire logic            PWRITE_I,
  input  wire logic [11:0]     PADDR_I,
  input  wire logic [31:0]     PWDATA_I,
  output logic      [31:0]     PRDATA_O,
  output logic                 PREADY_O,
  output logic                 PSLVERR_O,
  input  wire logic [NPIN-1:0] WAKEUP_PIN_INPUT_I,
  input  wire logic [NMOD-1:0] MODULE_WAKE_I,
  input  wire logic [2:0]      POWER_MODE_I,
  input  wire logic            DEBUG_ACTIVE_I,
  input  wire logic            REGULATOR_RUN_I,
  input  wire logic            LPO_TICK_I,
  input  wire logic            PAD_ISOLATE_SET_I,
  output logic                 WAKE_INTERRUPT_O,
  output logic                 WAKE_RESET_O,
  output logic                 PAD_ISOLATE_O,
  output logic                 BANDGAP_LOWPOWER_EN_O,
  output logic                 REFERENCE_BUFFER_EN_O
);
  localparam int NSEL = $clog2(NPIN);

  wake_state_t      state_reg;
  wake_state_t      state_next;
  logic [NPIN-1:0]  pin_meta_reg;
  logic [NPIN-1:0]  pin_sync_reg;
  logic [NPIN-1:0]  pin_prev_reg;
  logic [NMOD-1:0]  mod_meta_reg;
  logic [NMOD-1:0]  mod_sync_reg;
  logic [NPIN-1:0]  pin_eff;
  logic [NPIN-1:0]  pin_hit;
  logic [NPIN-1:0]  pin_hit_dly_reg;
  logic [NPIN-1:0]  pin_flag_reg;
  logic [NMOD-1:0]  mod_flag_reg;
  logic [31:0]      pin_edge_reg;
  logic [NMOD-1:0]  mod_enable_reg;
  logic [7:0]       filt_cfg_reg [NFILT];
  logic [NFILT-1:0] filt_level;
  logic [NFILT-1:0] filt_prev_reg;
  logic [NFILT-1:0] filt_hit;
  logic [NFILT-1:0] filt_flag_reg;
  logic             bg_keep_reg;
  logic             buf_en_reg;
  logic             iso_reg;
  logic             debug_entry_reg;
  logic             bg_req_reg;
  logic             detect_on;
  logic             bypass_filt;
  logic             any_wake;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic             mode_low;
  logic             mode_prev_low_reg;
  logic [1:0]       run_meta_reg;

  assign mode_low = (POWER_MODE_I != 3'(MODE_RUN));
  assign bypass_filt = (POWER_MODE_I == 3'(MODE_VLL0));
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;

  always_comb begin
    unique case (PADDR_I)
      `OFF_REGSC, `OFF_PIN_EDGE_LO, `OFF_PIN_EDGE_HI, `OFF_MOD_ENABLE,
      `OFF_PIN_FLAG, `OFF_MOD_FLAG, `OFF_FILT_CFG, `OFF_MODE_CTRL:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

  // Pin and module synchronisers
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
      mod_meta_reg <= '0;
      mod_sync_reg <= '0;
      run_meta_reg <= '0;
    end else begin
      pin_meta_reg <= WAKEUP_PIN_INPUT_I;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      mod_meta_reg <= MODULE_WAKE_I;
      mod_sync_reg <= mod_meta_reg;
      run_meta_reg <= {run_meta_reg[0], REGULATOR_RUN_I};
    end
  end

  // Per-pin edge decode
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      logic [1:0] sel;
      assign sel = pin_edge_reg[2*p +: 2];
      always_comb begin
        unique case (sel)
          `EDGE_RISE: pin_eff[p] = pin_sync_reg[p] & ~pin_prev_reg[p];
          `EDGE_FALL: pin_eff[p] = ~pin_sync_reg[p] & pin_prev_reg[p];
          `EDGE_ANY:  pin_eff[p] = pin_sync_reg[p] ^ pin_prev_reg[p];
          default:    pin_eff[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Hold edges seen at any time in run until the next entry so they still count
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_hit_dly_reg <= '0;
    end else if (detect_on || state_reg == ST_HOLD) begin
      pin_hit_dly_reg <= '0;
    end else begin
      pin_hit_dly_reg <= pin_hit_dly_reg | pin_eff;
    end
  end
  assign pin_hit = pin_eff | pin_hit_dly_reg;

  // Filters
  generate
    for (genvar f = 0; f < NFILT; f++) begin : g_filt
      logic [NSEL-1:0] fsel;
      logic [1:0]      fedge;
      logic            fpin;
      logic            fnow;
      logic            fprev;
      assign fsel  = filt_cfg_reg[f][`FILT_PIN_LSB +: NSEL];
      assign fedge = filt_cfg_reg[f][`FILT_EDGE_MSB:`FILT_EDGE_LSB];
      assign fpin  = pin_sync_reg[fsel];
      // Deepest mode: raw synchronised pin edge, filter skipped
      assign fnow  = bypass_filt ? fpin : filt_level[f];
      assign fprev = bypass_filt ? pin_prev_reg[fsel] : filt_prev_reg[f];
      wake_pin_filter #(.CNT_W(3)) u_filt (
        .clk_i   (SYS_CLK_I),
        .nrst_i  (NRST_I),
        .tick_i  (LPO_TICK_I),
        .pin_i   (fpin),
        .len_i   (`FILT_LEN),
        .level_o (filt_level[f])
      );
      always_comb begin
        unique case (fedge)
          `EDGE_RISE: filt_hit[f] = fnow & ~fprev;
          `EDGE_FALL: filt_hit[f] = ~fnow & fprev;
          `EDGE_ANY:  filt_hit[f] = fnow ^ fprev;
          default:    filt_hit[f] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      filt_prev_reg <= '0;
    end else begin
      filt_prev_reg <= filt_level;
    end
  end

  // Power-mode tracking
  assign detect_on = (state_reg == ST_LLS) || (state_reg == ST_VLLS);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
        if (mode_low && !mode_prev_low_reg) begin
          if (POWER_MODE_I == 3'(MODE_LLS))
            state_next = ST_LLS;
          else
            state_next = ST_VLLS;
        end
      ST_LLS:
        if (!mode_low)
          state_next = ST_RUN;
      ST_VLLS:
        if (!mode_low && debug_entry_reg)
          state_next = ST_RUN;
        else if (!mode_low)
          state_next = ST_HOLD;
      ST_HOLD:
        if (!iso_reg)
          state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg         <= ST_RUN;
      mode_prev_low_reg <= 1'b0;
      debug_entry_reg   <= 1'b0;
    end else begin
      state_reg         <= state_next;
      mode_prev_low_reg <= mode_low;
      if (state_reg == ST_RUN)
        debug_entry_reg <= DEBUG_ACTIVE_I;
    end
  end

  // Flags: set wins over software clear
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_flag_reg  <= '0;
      mod_flag_reg  <= '0;
      filt_flag_reg <= '0;
    end else begin
      logic [NPIN-1:0]  pset;
      logic [NMOD-1:0]  mset;
      logic [NFILT-1:0] fset;
      pset = '0;
      mset = '0;
      fset = '0;
      if (detect_on || state_reg == ST_HOLD) begin
        pset = pin_hit;
        mset = mod_sync_reg & mod_enable_reg;
        for (int f = 0; f < NFILT; f++)
          if (filt_cfg_reg[f][`FILT_EN_BIT]) begin
            fset[f] = filt_hit[f];
          end
      end
      if (wr_en && PADDR_I == `OFF_PIN_FLAG) begin
        pin_flag_reg  <= (pin_flag_reg & ~PWDATA_I[NPIN-1:0]) | pset;
        filt_flag_reg <= (filt_flag_reg & ~PWDATA_I[16 +: NFILT]) | fset;
      end else begin
        pin_flag_reg  <= pin_flag_reg | pset;
        filt_flag_reg <= filt_flag_reg | fset;
      end
      if (wr_en && PADDR_I == `OFF_MOD_FLAG)
        mod_flag_reg <= (mod_flag_reg & ~PWDATA_I[NMOD-1:0]) | mset;
      else
        mod_flag_reg <= mod_flag_reg | mset;
    end
  end

  assign any_wake = (|pin_flag_reg) || (|mod_flag_reg) || (|filt_flag_reg);

  // Exit flow outputs
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      WAKE_INTERRUPT_O <= 1'b0;
      WAKE_RESET_O     <= 1'b0;
    end else begin
      WAKE_INTERRUPT_O <= any_wake && state_reg == ST_LLS;
      WAKE_RESET_O     <= any_wake && state_reg == ST_VLLS;
    end
  end

  // Regulator control and isolation
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bg_keep_reg <= 1'b0;
      buf_en_reg  <= 1'b0;
      iso_reg     <= 1'b0;
    end else begin
      if (wr_en && PADDR_I == `OFF_REGSC) begin
        bg_keep_reg <= PWDATA_I[`BIT_BG_KEEP];
        buf_en_reg  <= PWDATA_I[`BIT_BUF_EN];
      end
      if (PAD_ISOLATE_SET_I)
        iso_reg <= 1'b1;
      else if (wr_en && PADDR_I == `OFF_REGSC && PWDATA_I[`BIT_ISO_ACK])
        iso_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bg_req_reg <= 1'b0;
    end else begin
      bg_req_reg <= !mode_low || bg_keep_reg;
    end
  end

  assign BANDGAP_LOWPOWER_EN_O = bg_req_reg;
  assign REFERENCE_BUFFER_EN_O = buf_en_reg;
  assign PAD_ISOLATE_O         = iso_reg;

  // Read mux
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PRDATA_O <= `RST_WORD;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= `RST_WORD;
      unique case (PADDR_I)
        `OFF_REGSC: begin
          PRDATA_O[`BIT_BG_KEEP] <= bg_keep_reg;
          PRDATA_O[`BIT_ISO_ACK] <= iso_reg;
          PRDATA_O[`BIT_REG_RUN] <= run_meta_reg[1];
          PRDATA_O[`BIT_BUF_EN]  <= buf_en_reg;
        end
        `OFF_PIN_EDGE_LO: PRDATA_O[15:0] <= pin_edge_reg[15:0];
        `OFF_PIN_EDGE_HI: PRDATA_O[15:0] <= pin_edge_reg[31:16];
        `OFF_MOD_ENABLE:  PRDATA_O[NMOD-1:0] <= mod_enable_reg;
        `OFF_PIN_FLAG: begin
          PRDATA_O[NPIN-1:0]    <= pin_flag_reg;
          PRDATA_O[16 +: NFILT] <= filt_flag_reg;
        end
        `OFF_MOD_FLAG: PRDATA_O[NMOD-1:0] <= mod_flag_reg;
        `OFF_FILT_CFG: begin
          PRDATA_O[7:0]  <= filt_cfg_reg[0];
          PRDATA_O[15:8] <= filt_cfg_reg[1];
        end
        `OFF_MODE_CTRL: PRDATA_O[3:0] <= state_reg;
        default: PRDATA_O <= `ERR_DATA;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_edge_reg    <= `RST_WORD;
      mod_enable_reg  <= '0;
      filt_cfg_reg[0] <= 8'h00;
      filt_cfg_reg[1] <= 8'h00;
    end else if (wr_en) begin
      unique case (PADDR_I)
        `OFF_PIN_EDGE_LO: pin_edge_reg[15:0]  <= PWDATA_I[15:0];
        `OFF_PIN_EDGE_HI: pin_edge_reg[31:16] <= PWDATA_I[15:0];
        `OFF_MOD_ENABLE:  mod_enable_reg      <= PWDATA_I[NMOD-1:0];
        `OFF_FILT_CFG: begin
          filt_cfg_reg[0] <= PWDATA_I[7:0];
          filt_cfg_reg[1] <= PWDATA_I[15:8];
        end
        default: ;
      endcase
    end
  end

  // Assertions
  chk_iso_release: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (iso_reg && !PAD_ISOLATE_SET_I && wr_en && PADDR_I == `OFF_REGSC
     && PWDATA_I[`BIT_ISO_ACK]) |=> !PAD_ISOLATE_O)
    else $error("isolation not released");
  chk_lls_exit: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_reg == ST_LLS && !mode_low) |=> state_reg == ST_RUN)
    else $error("unit not disabled after stop exit");
  chk_irq_flow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_reg == ST_LLS && any_wake) |=> WAKE_INTERRUPT_O)
    else $error("no interrupt flow");
  chk_reset_flow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_reg == ST_VLLS && any_wake) |=> WAKE_RESET_O)
    else $error("no reset flow");
  chk_flag_idle: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_reg == ST_RUN && !wr_en) |=> $stable(mod_flag_reg))
    else $error("flag moved while idle");
  chk_flag_sticky: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (|pin_flag_reg && !wr_en) |=> |pin_flag_reg)
    else $error("flag lost");
  chk_buf_follow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (wr_en && PADDR_I == `OFF_REGSC) |=>
    REFERENCE_BUFFER_EN_O == $past(PWDATA_I[`BIT_BUF_EN]))
    else $error("buffer enable wrong");
  chk_bg_keep: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (mode_low && bg_keep_reg) |=> BANDGAP_LOWPOWER_EN_O)
    else $error("bandgap dropped");
  chk_hold_iso: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_reg == ST_HOLD && iso_reg) |=> state_reg == ST_HOLD)
    else $error("left hold before acknowledge");
endmodule // wakeup_unit

// ==== wake_source_model.sv ====
// Wakeup pins, peripheral wake sources and the low-power tick
`timescale 1ns/1ps
module wake_source_model (
  input  wire logic        clk_i,
  output logic      [15:0] pin_o,
  output logic      [7:0]  mod_o,
  output logic             tick_o
);
  logic [1:0] div_reg;

  initial begin
    pin_o   = 16'h0000;
    mod_o   = 8'h00;
    tick_o  = 1'b0;
    div_reg = 2'h0;
  end

  // One oscillator tick every four system clocks
  always @(posedge clk_i) begin
    div_reg <= div_reg + 2'h1;
    tick_o  <= (div_reg == 2'h3);
  end

  task automatic set_pin(input int p, input logic v);
    @(posedge clk_i);
    pin_o[p] <= v;
  endtask

  task automatic pulse_pin(input int p, input int len);
    set_pin(p, 1'b1);
    repeat (len - 1) @(posedge clk_i);
    set_pin(p, 1'b0);
  endtask

  task automatic pulse_mods(input logic [7:0] m, input int len);
    @(posedge clk_i);
    mod_o <= m;
    repeat (len) @(posedge clk_i);
    mod_o <= 8'h00;
  endtask
endmodule // wake_source_model

// ==== tb_wakeup_unit.sv ====
// Self-checking testbench of the wakeup unit
`timescale 1ns/1ps
module tb_wakeup_unit;
  import wakeup_unit_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, dbg, reg_run, iso_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [2:0]  mode;
  logic [15:0] pins;
  logic [7:0]  mods;
  logic        tick, pready, pslverr, wirq, wrst, iso, bg, buf_en, err;
  int          num_errors, comparisons, seed, p, v;

  always #12.5 clk = ~clk;

  wake_source_model i_src (.clk_i(clk), .pin_o(pins), .mod_o(mods),
                           .tick_o(tick));

  wakeup_unit i_dut (
    .SYS_CLK_I            (clk),
    .NRST_I               (nrst),
    .PSEL_I               (psel),
    .PENABLE_I            (penable),
    .PWRITE_I             (pwrite),
    .PADDR_I              (paddr),
    .PWDATA_I             (pwdata),
    .PRDATA_O             (prdata),
    .PREADY_O             (pready),
    .PSLVERR_O            (pslverr),
    .WAKEUP_PIN_INPUT_I   (pins),
    .MODULE_WAKE_I        (mods),
    .POWER_MODE_I         (mode),
    .DEBUG_ACTIVE_I       (dbg),
    .REGULATOR_RUN_I      (reg_run),
    .LPO_TICK_I           (tick),
    .PAD_ISOLATE_SET_I    (iso_set),
    .WAKE_INTERRUPT_O     (wirq),
    .WAKE_RESET_O         (wrst),
    .PAD_ISOLATE_O        (iso),
    .BANDGAP_LOWPOWER_EN_O(bg),
    .REFERENCE_BUFFER_EN_O(buf_en)
  );

  function automatic logic [31:0] regsc_exp(logic [31:0] w, logic run);
    return (w & 32'h0000_0011) | {29'h0, run, 2'h0};
  endfunction

  function automatic logic edge_hit(logic [1:0] code, logic rising);
    return rising ? code[0] : code[1];
  endfunction

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic set_mode(input logic [2:0] m, input int n);
    @(posedge clk);
    mode <= m;
    repeat (n) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 3'h0;
    dbg = 1'b0;
    reg_run = 1'b1;
    iso_set = 1'b0;
    num_errors = 0;
    comparisons = 0;
    seed = 32'hB80E0800;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(12'h000, 32'h0000_0004);
    rdchk(12'h004, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'hDEAD_0000);
    chk({31'h0, err}, 32'h1);
    // Random control words, reserved bit kept clear
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 32'hFFFF_FFFD;
      @(posedge clk);
      reg_run <= v[8];
      wr(12'h000, v);
      repeat (3) @(posedge clk);
      rdchk(12'h000, regsc_exp(v, v[8]));
      chk({31'h0, buf_en}, {31'h0, v[0]});
      set_mode(3'h1, 3);
      chk({31'h0, bg}, {31'h0, v[4]});
      set_mode(3'h0, 3);
      chk({31'h0, bg}, 32'h1);
    end
    // Every edge code, rising then falling
    for (int c = 0; c < 4; c++) begin
      p = $unsigned($random(seed)) % 16;
      wr(p < 8 ? 12'h004 : 12'h008, c << (2 * (p % 8)));
      set_mode(3'h1, 2);
      i_src.set_pin(p, 1'b1);
      repeat (12) @(posedge clk);
      chk({31'h0, wirq}, 32'(edge_hit(c[1:0], 1'b1)));
      rdchk(12'h010, 32'(edge_hit(c[1:0], 1'b1)) << p);
      wr(12'h010, 32'hFFFF_FFFF);
      i_src.set_pin(p, 1'b0);
      repeat (12) @(posedge clk);
      rdchk(12'h010, 32'(edge_hit(c[1:0], 1'b0)) << p);
      wr(12'h010, 32'hFFFF_FFFF);
      set_mode(3'h0, 2);
    end
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
    // Edge in run is ignored, then caught at a prompt entry
    p = $unsigned($random(seed)) % 16;
    wr(p < 8 ? 12'h004 : 12'h008, 32'h1 << (2 * (p % 8)));
    i_src.set_pin(p, 1'b1);
    repeat (6) @(posedge clk);
    chk({31'h0, wirq}, 32'h0);
    rdchk(12'h010, 32'h0);
    set_mode(3'h1, 12);
    chk({31'h0, wirq}, 32'h1);
    rdchk(12'h010, 32'h1 << p);
    i_src.set_pin(p, 1'b0);
    wr(12'h010, 32'hFFFF_FFFF);
    set_mode(3'h0, 2);
    rdchk(12'h01C, 32'h1);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
    // Deep mode exit, with and without debug
    for (int d = 0; d < 2; d++) begin
      p = $unsigned($random(seed)) % 8;
      wr(12'h00C, 32'h1 << p);
      @(posedge clk);
      dbg     <= d[0];
      iso_set <= 1'b1;
      set_mode(3'h2, 1);
      iso_set <= 1'b0;
      i_src.pulse_mods(8'hFF, 4);
      repeat (12) @(posedge clk);
      chk({31'h0, wrst}, 32'h1);
      rdchk(12'h014, 32'h1 << p);
      set_mode(3'h0, 3);
      rdchk(12'h01C, d ? 32'h1 : 32'h8);
      wr(12'h014, 32'hFF);
      i_src.pulse_mods(8'hFF, 4);
      repeat (12) @(posedge clk);
      rdchk(12'h014, d ? 32'h0 : 32'h1 << p);
      wr(12'h014, 32'hFF);
      apb(1'b0, 12'h000, 32'h0);
      chk({31'h0, rd[3]}, 32'h1);
      wr(12'h000, 32'h8);
      rdchk(12'h01C, 32'h1);
      chk({31'h0, iso}, 32'h0);
    end
    // Filters: short glitch, long pulse, deepest mode bypass
    for (int k = 0; k < 3; k++) begin
      p = $unsigned($random(seed)) % 16;
      v = $unsigned($random(seed)) % 2;
      wr(12'h018, (32'h90 | p) << (8 * v));
      set_mode((k == 2) ? 3'h3 : 3'h1, 2);
      i_src.pulse_pin(p, (k == 1) ? 40 : 2);
      repeat (30) @(posedge clk);
      rdchk(12'h010, (k == 0) ? 32'h0 : 32'h1 << (16 + v));
      wr(12'h010, 32'hFFFF_FFFF);
      set_mode(3'h0, 2);
      wr(12'h000, 32'h8);
    end
    complete_run();
  end
endmodule // tb_wakeup_unit
